// ### design/tas_pkg.sv
// constants and types shared by the touch converter sequencer
package tas_pkg;

   // ****************************************
   // control word layout
   // ****************************************
   localparam int CTRL_BITS = 8;
   localparam int CTRL_START_BIT = 7;
   localparam int CTRL_CHAN_HI = 6;
   localparam int CTRL_CHAN_LO = 4;
   localparam int CTRL_MODE_BIT = 3;
   localparam int CTRL_REF_BIT = 2;
   localparam int CTRL_PD_HI = 1;
   localparam int CTRL_PD_LO = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ****************************************
   // channel codes
   // ****************************************
   localparam logic [2:0] CHAN_X_PLUS = 3'h1;
   localparam logic [2:0] CHAN_Y_PLUS = 3'h5;
   localparam logic [2:0] CHAN_AUX_A = 3'h2;
   localparam logic [2:0] CHAN_AUX_B = 3'h6;

   // ****************************************
   // frame timing in shift-clock counts
   // ****************************************
   localparam logic [4:0] CNT_SAMPLE_START = 5'h05;
   localparam logic [4:0] CNT_HOLD = 5'h08;
   localparam logic [4:0] CNT_FIRST_DECIDE = 5'h0a;
   localparam logic [4:0] CNT_LAST_DECIDE = 5'h15;
   localparam logic [4:0] CNT_FRAME_END = 5'h18;
   localparam int RESULT_W = 12;
   localparam int RESULT_STEPS = 4096;
   localparam int RESULT_8BIT_DROP = 4;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [11:0] TRIAL_MSB = 12'h800;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {POS_X_PLUS, POS_Y_PLUS, POS_AUX_A, POS_AUX_B} tas_pos_type;
   typedef enum logic [2:0] {ST_IDLE, ST_CTRL, ST_SAMPLE, ST_CONVERT, ST_TAIL} tas_state_type;

endpackage

// ### design/tas_cfg_if.sv
// channel selection carried between sequencer and decoder
`timescale 1ns/1ps
interface tas_cfg_if;
   import tas_pkg::*;
   logic [2:0] channel_code;
   logic reference_mode_select;
   logic x_drivers_on;
   logic y_drivers_on;
   tas_pos_type pos_sel;
   logic sel_valid;
   logic ratio_ref;

   modport dec (input channel_code, input reference_mode_select, output x_drivers_on, output y_drivers_on,
                output pos_sel, output sel_valid, output ratio_ref);
   modport seq (output channel_code, output reference_mode_select, input x_drivers_on, input y_drivers_on,
                input pos_sel, input sel_valid, input ratio_ref);
endinterface

// ### design/tas_chan_decode.sv
// decodes channel code and reference mode into switch settings
`timescale 1ns/1ps
module tas_chan_decode
(
   tas_cfg_if.dec cfg
);
   import tas_pkg::*;

   // ****************************************
   // decode
   // ****************************************
   always_comb
   begin
      cfg.x_drivers_on = 1'b0;
      cfg.y_drivers_on = 1'b0;
      cfg.pos_sel = POS_AUX_A;
      cfg.sel_valid = 1'b1;
      cfg.ratio_ref = 1'b0;
      unique case (cfg.channel_code)
         CHAN_X_PLUS:
         begin
            cfg.pos_sel = POS_X_PLUS; // R11
            cfg.y_drivers_on = 1'b1; // R11
            cfg.ratio_ref = ~cfg.reference_mode_select; // R12
         end
         CHAN_Y_PLUS:
         begin
            cfg.pos_sel = POS_Y_PLUS; // R11
            cfg.x_drivers_on = 1'b1; // R11
            cfg.ratio_ref = ~cfg.reference_mode_select; // R12
         end
         CHAN_AUX_A: cfg.pos_sel = POS_AUX_A; // R11
         CHAN_AUX_B: cfg.pos_sel = POS_AUX_B; // R11
         default: cfg.sel_valid = 1'b0; // R18
      endcase
   end

endmodule

// ### design/tas_sequencer.sv
// serial control sequencer of the touch screen converter
// Function
// R1 - all sequencing stepped by host shift clock
// R2 - conversion frame is three eight-clock transfers
// R3 - host sends control word first eight clocks
// R4 - sample and drivers on once channel known
// R5 - hold and convert three clocks after sampling
// R6 - hold captures positive minus negative input
// R7 - twelve decisions after hold, one per clock
// R8 - ratiometric keeps drivers on during conversion
// R9 - thirteenth conversion clock shows result LSB
// R10 - last three clocks output low, ignored
// R11 - single-ended channel routing and driver table
// R12 - ratiometric takes reference from driven electrodes
// R13 - twelve-bit result, span over 4096 steps
// R14 - serial input ignored until high start bit
// R15 - control word field layout
// R16 - input sampled on shift-clock rise, select low
// R17 - output changes on fall, released when deselected
// R18 - unlisted channel codes leave drivers off
// R19 - deselect mid-frame returns to start wait
`timescale 1ns/1ps
module tas_sequencer
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // serial port
   input wire logic serial_shift_clock_in,
   input wire logic cs_n_in,
   input wire logic din_in,
   output logic dout_out,
   output logic dout_oe_out,
   // analog front end
   input wire logic comparator_in,
   output logic sample_out,
   output logic hold_out,
   output logic x_drivers_on_out,
   output logic y_drivers_on_out,
   output tas_pkg::tas_pos_type pos_sel_out,
   output logic neg_from_drivers_out,
   output logic ref_from_drivers_out,
   output logic [tas_pkg::RESULT_W-1:0] dac_trial_out,
   // status
   output logic [2:0] channel_code_out,
   output logic reference_mode_select_out,
   output logic mode_8bit_out,
   output logic [1:0] power_down_select_out,
   output logic sel_valid_out,
   output logic [tas_pkg::RESULT_W-1:0] result_out,
   output logic result_valid_out
);
   import tas_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta;
   logic rst_n;
   logic next_rst_meta;
   logic next_rst_n;

   always_comb
   begin
      next_rst_meta = 1'b1;
      next_rst_n = rst_meta;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= next_rst_meta;
         rst_n <= next_rst_n;
      end
   end

   // ****************************************
   // shift clock edge enables
   // ****************************************
   logic sclk_q;
   logic next_sclk_q;
   logic sclk_rise;
   logic sclk_fall;

   // shift clock is plain data here, compared with its last core-cycle copy
   always_comb
   begin
      next_sclk_q = serial_shift_clock_in;
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
         sclk_q <= 1'b0;
      else
         sclk_q <= next_sclk_q;
   end

   assign sclk_rise = serial_shift_clock_in & ~sclk_q; // R1
   assign sclk_fall = ~serial_shift_clock_in & sclk_q; // R1

   // ****************************************
   // sequencer state
   // ****************************************
   tas_state_type state;
   tas_state_type next_state;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [2:0] chan;
   logic [2:0] next_chan;
   logic ref_sel;
   logic next_ref_sel;
   logic mode8;
   logic next_mode8;
   logic [1:0] pd_sel;
   logic [1:0] next_pd_sel;
   logic [RESULT_W-1:0] trial;
   logic [RESULT_W-1:0] next_trial;
   logic [RESULT_W-1:0] result;
   logic [RESULT_W-1:0] next_result;
   logic result_valid;
   logic next_result_valid;
   logic dout;
   logic next_dout;

   tas_cfg_if cfg ();

   tas_chan_decode u_decode
   (
      .cfg(cfg.dec)
   );

   assign cfg.channel_code = chan;
   assign cfg.reference_mode_select = ref_sel;

   // ****************************************
   // frame position and bit decision
   // ****************************************
   logic [3:0] idx;
   logic low_forced;
   logic keep;

   function automatic logic in_window(input logic [4:0] pos, input logic [4:0] first, input logic [4:0] last);
      in_window = (pos >= first) && (pos <= last);
   endfunction

   always_comb
   begin
      idx = 4'(CNT_LAST_DECIDE - cnt);
      low_forced = mode8 & (idx < 4'(RESULT_8BIT_DROP)); // R15
      keep = comparator_in & ~low_forced; // R7
   end

   // ****************************************
   // sequencer next state
   // ****************************************
   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_ctrl = ctrl;
      next_chan = chan;
      next_ref_sel = ref_sel;
      next_mode8 = mode8;
      next_pd_sel = pd_sel;
      next_trial = trial;
      next_result = result;
      next_result_valid = 1'b0;
      next_dout = dout;
      if (cs_n_in)
      begin
         next_state = ST_IDLE; // R19
         next_cnt = 5'h00;
         next_trial = RESULT_RESET;
         next_dout = 1'b0;
      end
      else if (sclk_rise)
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (din_in) // R14 R16
               begin
                  next_state = ST_CTRL;
                  next_cnt = 5'h01;
                  next_ctrl = 8'h01;
               end
            end
            default:
            begin
               next_cnt = cnt + 5'h01; // R2
               if (cnt < 5'(CTRL_BITS))
                  next_ctrl = {ctrl[6:0], din_in}; // R3 R16
            end
         endcase
      end
      else if (sclk_fall && state != ST_IDLE)
      begin
         if (cnt == CNT_SAMPLE_START)
         begin
            next_state = ST_SAMPLE; // R4
            next_chan = ctrl[CTRL_CHAN_HI-CTRL_MODE_BIT:CTRL_CHAN_LO-CTRL_MODE_BIT]; // R15
         end
         else if (cnt == CNT_HOLD)
         begin
            next_state = ST_CONVERT; // R5 R6
            next_mode8 = ctrl[CTRL_MODE_BIT]; // R15
            next_ref_sel = ctrl[CTRL_REF_BIT]; // R15
            next_pd_sel = ctrl[CTRL_PD_HI:CTRL_PD_LO]; // R15
            next_trial = TRIAL_MSB; // R13
            next_result = RESULT_RESET;
         end
         else if (in_window(cnt, CNT_FIRST_DECIDE, CNT_LAST_DECIDE))
         begin
            next_result[idx] = keep; // R7
            next_trial[idx] = keep; // R7
            next_dout = keep; // R17 R9
            if (idx != 4'h0)
               next_trial[idx-4'h1] = 1'b1; // R7
            if (cnt == CNT_LAST_DECIDE)
            begin
               next_state = ST_TAIL; // R9
               next_result_valid = 1'b1;
            end
         end
         else if (in_window(cnt, CNT_LAST_DECIDE + 5'h01, CNT_FRAME_END))
         begin
            next_dout = 1'b0; // R10
            if (cnt == CNT_FRAME_END)
            begin
               next_state = ST_IDLE; // R2 R10
               next_cnt = 5'h00;
            end
         end
         else
            next_dout = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         cnt <= 5'h00;
         ctrl <= CTRL_RESET;
         chan <= 3'h0;
         ref_sel <= 1'b1;
         mode8 <= 1'b0;
         pd_sel <= 2'h0;
         trial <= RESULT_RESET;
         result <= RESULT_RESET;
         result_valid <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         ctrl <= next_ctrl;
         chan <= next_chan;
         ref_sel <= next_ref_sel;
         mode8 <= next_mode8;
         pd_sel <= next_pd_sel;
         trial <= next_trial;
         result <= next_result;
         result_valid <= next_result_valid;
         dout <= next_dout;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   logic drive_en;

   // drivers during sampling, and through conversion only when ratiometric
   assign drive_en = (state == ST_SAMPLE) || (state == ST_CONVERT && cfg.ratio_ref); // R4 R5 R8
   assign x_drivers_on_out = drive_en & cfg.x_drivers_on; // R8 R18
   assign y_drivers_on_out = drive_en & cfg.y_drivers_on; // R8 R18
   assign pos_sel_out = cfg.pos_sel;
   assign neg_from_drivers_out = cfg.ratio_ref; // R12
   assign ref_from_drivers_out = cfg.ratio_ref; // R12
   assign sel_valid_out = cfg.sel_valid;
   assign sample_out = (state == ST_SAMPLE); // R4
   assign hold_out = (state == ST_CONVERT); // R6
   assign dac_trial_out = trial;
   assign dout_out = dout; // R17
   assign dout_oe_out = ~cs_n_in; // R17
   assign channel_code_out = chan;
   assign reference_mode_select_out = ref_sel;
   assign mode_8bit_out = mode8;
   assign power_down_select_out = pd_sel;
   assign result_out = result; // R13
   assign result_valid_out = result_valid;

endmodule

// ### verification/tas_checker.sv
// port assertions for the touch converter sequencer
`timescale 1ns/1ps
module tas_checker
(
   // watched ports
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic cs_n_in,
   input wire logic dout_out,
   input wire logic dout_oe_out,
   input wire logic sample_out,
   input wire logic hold_out,
   input wire logic x_drivers_on_out,
   input wire logic y_drivers_on_out,
   input wire logic [tas_pkg::RESULT_W-1:0] dac_trial_out,
   input wire logic reference_mode_select_out,
   input wire logic sel_valid_out,
   input wire logic result_valid_out
);
   import tas_pkg::*;
   // ****
   // properties
   // ****
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire logic drv = x_drivers_on_out || y_drivers_on_out;
   oe_follows_cs_a: assert property (dout_oe_out == !cs_n_in)
      else $error("output enable differs from select");
   abort_idle_a: assert property (cs_n_in [*3] |-> !dout_out && !sample_out && !hold_out)
      else $error("deselect left sequencer busy");
   phase_excl_a: assert property (!(sample_out && hold_out))
      else $error("sample and hold together");
   hold_trial_a: assert property ($rose(hold_out) |-> dac_trial_out == TRIAL_MSB && $past(sample_out))
      else $error("hold entry wrong");
   ratio_keep_a: assert property ($rose(hold_out) && !reference_mode_select_out && $past(drv) |-> drv)
      else $error("drivers dropped in ratio hold");
   drv_off_a: assert property (!sample_out && !(hold_out && !reference_mode_select_out) |-> !drv)
      else $error("drivers on outside their phase");
   unlisted_off_a: assert property (!sel_valid_out |-> !drv)
      else $error("drivers on for unlisted code");
   valid_end_a: assert property (result_valid_out |-> $fell(hold_out))
      else $error("result valid not at conversion end");
   end_cov: cover property ($rose(result_valid_out));
   ratio_cov: cover property ($rose(hold_out) && !reference_mode_select_out && drv);
   abort_cov: cover property ($rose(cs_n_in) && hold_out);
endmodule
bind tas_sequencer tas_checker chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
   .dout_out(dout_out), .dout_oe_out(dout_oe_out), .sample_out(sample_out), .hold_out(hold_out),
   .x_drivers_on_out(x_drivers_on_out), .y_drivers_on_out(y_drivers_on_out), .dac_trial_out(dac_trial_out),
   .reference_mode_select_out(reference_mode_select_out), .sel_valid_out(sel_valid_out),
   .result_valid_out(result_valid_out));

// ### verification/tas_host.sv
// host serial port model that frames transfers into the sequencer
`timescale 1ns/1ps
module tas_host
(
   // serial port
   input wire logic core_clk_in,
   input wire logic dout_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out
);
   // ****
   // frame driver
   // ****
   initial
   begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   end
   // idle lead clocks then 24, cut before rise stop
   task automatic xfer(input logic [7:0] c, input int lead, input int stop, output logic [11:0] r,
                       output logic t);
      int j;
      r = 12'h000;
      t = 1'b0;
      cs_n_out = 1'b0;
      repeat (2) @(negedge core_clk_in);
      for (int k = 1; k <= lead + 24 && k != stop; k++)
      begin
         j = k - lead;
         din_out = (j >= 1 && j <= 8) ? c[8 - j] : (j > 8 && k[0]);
         sclk_out = 1'b1;
         repeat (4) @(negedge core_clk_in);
         sclk_out = 1'b0;
         repeat (4) @(negedge core_clk_in);
         if (j >= 10 && j <= 21)
            r[21 - j] = dout_in;
         if (j >= 22)
            t = t | dout_in;
      end
      cs_n_out = 1'b1;
      din_out = !din_out;
      repeat (2) @(negedge core_clk_in);
   endtask
endmodule

// ### verification/touch_adc_serial_sequencer_bench.sv
// self-checking bench for the touch converter sequencer
`timescale 1ns/1ps
module touch_adc_serial_sequencer_bench;
   import tas_pkg::*;
   logic clk, rst_n, sclk, cs_n, din, dout, oe, cmp, smp, hld, xd, yd, negd, refd, rm, m8, sv, rv, t, f;
   logic [2:0] ch, c;
   logic [1:0] pd, sd, hd;
   logic [11:0] dac, res, vin, e, r;
   tas_pos_type pos;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_valid = 0;
   logic pclr = 1'b0;
   int i;
   tas_sequencer dut (.core_clk_in(clk), .rst_n_in(rst_n), .serial_shift_clock_in(sclk), .cs_n_in(cs_n),
      .din_in(din), .dout_out(dout), .dout_oe_out(oe), .comparator_in(cmp), .sample_out(smp), .hold_out(hld),
      .x_drivers_on_out(xd), .y_drivers_on_out(yd), .pos_sel_out(pos), .neg_from_drivers_out(negd),
      .ref_from_drivers_out(refd), .dac_trial_out(dac), .channel_code_out(ch), .reference_mode_select_out(rm),
      .mode_8bit_out(m8), .power_down_select_out(pd), .sel_valid_out(sv), .result_out(res),
      .result_valid_out(rv));
   tas_host host (.core_clk_in(clk), .dout_in(dout), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));
   // ****
   // clock, analog model, probes
   // ****
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(negedge clk) cmp <= (vin >= dac);
   always @(negedge clk)
   begin
      if (pclr)
      begin
         sd <= 'x;
         hd <= 'x;
      end
      if (smp)
         sd <= {xd, yd};
      if (hld)
         hd <= {xd, yd};
      if (rv)
         n_valid++;
   end
   task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ****
   // tests
   // ****
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      vin = 12'h000;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (i = 0; i < 16; i++)
      begin
         c = 3'(i);
         f = (i < 8);
         vin = 12'(i * 273);
         e = (i == 7) ? (vin & 12'hff0) : vin;
         pclr <= 1'b1;
         @(negedge clk);
         pclr <= 1'b0;
         host.xfer({1'b1, c, i == 7, f, 2'(i)}, i % 3, 0, r, t);
         chk("dout", r, e);
         chk("result", res, e);
         chk("tail", 12'(t), 12'h000);
         chk("fields", 12'({ch, m8, rm, pd}), 12'({c, i == 7, f, 2'(i)}));
         chk("sample drv", 12'(sd), 12'({c == 5, c == 1}));
         chk("hold drv", 12'(hd), f ? 12'h000 : 12'({c == 5, c == 1}));
         chk("ratio", 12'({negd, refd, sv}), 12'({{2{!f && c[1:0] == 2'h1}}, c[1:0] == 2'h1 || c[1:0] == 2'h2}));
         chk("pos", 12'(pos), 12'(c == 1 ? POS_X_PLUS : c == 5 ? POS_Y_PLUS : c == 6 ? POS_AUX_B : POS_AUX_A));
         chk("released", 12'({oe, hld, smp}), 12'h000);
      end
      chk("valid pulses", 12'(n_valid), 12'h010);
      host.xfer(8'h95, 0, 12, r, t);
      repeat (3) @(negedge clk);
      chk("abort", 12'({oe, hld, smp, dout}), 12'h000);
      vin = 12'h7ff;
      host.xfer(8'h94, 2, 0, r, t);
      chk("after abort", res, 12'h7ff);
      chk("valid total", 12'(n_valid), 12'h011);
      give_verdict();
   end
endmodule
